// ---- verilog/rxevc_map.svh ----
// Purpose: Offsets, field positions, reset values and response codes of the receive
//          error event counters.
// Assumes: Register indices are multiplied by four to form AXI4-Lite byte addresses.
// Notes:   Definitions only.
`ifndef RXEVC_MAP_SVH
`define RXEVC_MAP_SVH

`define RXEVC_ADDR_W          8
`define RXEVC_DATA_W          32
`define RXEVC_CNT_W           12
`define RXEVC_NUM_CNT         4

`define RXEVC_IDX_CONTROL     8'h00
`define RXEVC_IDX_BAD_CSUM    8'h0A
`define RXEVC_IDX_FILT_REJ    8'h0C
`define RXEVC_IDX_OVERRUN     8'h0E
`define RXEVC_IDX_DLM_TMO     8'h10

`define RXEVC_BIT_CNT_EN      0
`define RXEVC_CNT_RESET       12'h000
`define RXEVC_CNT_ONE         12'h001
`define RXEVC_EN_RESET        1'b0

`define RXEVC_RESP_OKAY       2'b00
`define RXEVC_RESP_SLVERR     2'b10

`endif

// ---- verilog/rxevc_pkg.sv ----
// Purpose: Types shared by the receive error event counters.
// Assumes: Widths come from rxevc_map.svh.
// Notes:   Slot order of the counter array is fixed by rxevc_slot_type.
`include "rxevc_map.svh"

package rxevc_pkg;

  typedef logic [`RXEVC_CNT_W-1:0]  rxevc_count_type;
  typedef logic [`RXEVC_ADDR_W-1:0] rxevc_addr_type;
  typedef logic [`RXEVC_DATA_W-1:0] rxevc_data_type;
  typedef logic [1:0]               rxevc_resp_type;

  typedef enum {
    RXEVC_SLOT_BAD_CSUM,
    RXEVC_SLOT_FILT_REJ,
    RXEVC_SLOT_OVERRUN,
    RXEVC_SLOT_DLM_TMO
  } rxevc_slot_type;

endpackage

// ---- verilog/rxevc_counters.sv ----
// Purpose: Receive error event counters read over an AXI4-Lite slave.
// Assumes: Event inputs come from status logic on SYS_CLK_I and are one-cycle pulses,
//          except RX_OVERRUN_FLAG_I, which is a level.
// Notes:   Counters wrap modulo 4096; reads return the value before a same-cycle increment.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "rxevc_map.svh"

module rxevc_counters
  import rxevc_pkg::*;
(
  input  wire logic                SYS_CLK_I,                   // System clock, 50 MHz
  input  wire logic                RST_I,                       // Async reset, active high
  input  wire logic                RX_CHECKSUM_ERROR_FLAG_I,    // Bad checksum event pulse
  input  wire logic                FILTER_REJECT_FLAG_I,        // Filter reject event pulse
  input  wire logic                RX_OVERRUN_FLAG_I,           // Overrun condition level
  input  wire logic                RX_FRAME_DISCARD_I,          // Frame discarded pulse
  input  wire logic                RX_DELIMITER_TIMEOUT_FLAG_I, // Delimiter timeout pulse
  input  wire rxevc_pkg::rxevc_addr_type S_AXI_AWADDR,          // Write address
  input  wire logic                S_AXI_AWVALID,               // Write address valid
  output logic                     S_AXI_AWREADY,               // Write address ready
  input  wire rxevc_pkg::rxevc_data_type S_AXI_WDATA,           // Write data
  input  wire logic [3:0]          S_AXI_WSTRB,                 // Write byte strobes
  input  wire logic                S_AXI_WVALID,                // Write data valid
  output logic                     S_AXI_WREADY,                // Write data ready
  output rxevc_pkg::rxevc_resp_type S_AXI_BRESP,                // Write response
  output logic                     S_AXI_BVALID,                // Write response valid
  input  wire logic                S_AXI_BREADY,                // Write response ready
  input  wire rxevc_pkg::rxevc_addr_type S_AXI_ARADDR,          // Read address
  input  wire logic                S_AXI_ARVALID,               // Read address valid
  output logic                     S_AXI_ARREADY,               // Read address ready
  output rxevc_pkg::rxevc_data_type S_AXI_RDATA,                // Read data
  output rxevc_pkg::rxevc_resp_type S_AXI_RRESP,                // Read response
  output logic                     S_AXI_RVALID,                // Read data valid
  input  wire logic                S_AXI_RREADY                 // Read data ready
);
  import rxevc_pkg::*;

  logic                       cnt_en_q;
  rxevc_count_type            count_q [`RXEVC_NUM_CNT];
  logic [`RXEVC_NUM_CNT-1:0]  event_hit;

  logic                       awready_q;
  logic                       wready_q;
  logic                       aw_full_q;
  logic                       w_full_q;
  rxevc_addr_type             waddr_q;
  rxevc_data_type             wdata_q;
  logic [3:0]                 wstrb_q;
  logic                       bvalid_q;
  rxevc_resp_type             bresp_q;
  logic                       arready_q;
  logic                       rvalid_q;
  rxevc_data_type             rdata_q;
  rxevc_resp_type             rresp_q;
  logic                       wr_fire;
  logic [`RXEVC_DATA_W:0]     rd_word;

  // The overrun counter follows discards only while the overrun flag stands, so a
  // persistent overrun is counted once per lost frame rather than once per cycle.
  always_comb
  begin
    event_hit                      = '0;
    event_hit[RXEVC_SLOT_BAD_CSUM] = RX_CHECKSUM_ERROR_FLAG_I;
    event_hit[RXEVC_SLOT_FILT_REJ] = FILTER_REJECT_FLAG_I;
    event_hit[RXEVC_SLOT_OVERRUN]  = RX_OVERRUN_FLAG_I & RX_FRAME_DISCARD_I;
    event_hit[RXEVC_SLOT_DLM_TMO]  = RX_DELIMITER_TIMEOUT_FLAG_I;
  end

  for (genvar g = 0; g < `RXEVC_NUM_CNT; g++)
  begin : g_cnt
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
      if (RST_I)
      begin
        count_q[g] <= `RXEVC_CNT_RESET;
      end
      else if (cnt_en_q && event_hit[g])
      begin
        count_q[g] <= count_q[g] + `RXEVC_CNT_ONE;
      end
    end
  end

  function automatic logic [`RXEVC_DATA_W:0] rd_decode(input rxevc_addr_type a);
    logic [`RXEVC_ADDR_W-3:0] idx;
    idx = a[`RXEVC_ADDR_W-1:2];
    rd_decode = {1'b1, {`RXEVC_DATA_W{1'b0}}};
    if (idx == `RXEVC_IDX_CONTROL)
    begin
      rd_decode = '0;
      rd_decode[`RXEVC_BIT_CNT_EN] = cnt_en_q;
    end
    else if (idx == `RXEVC_IDX_BAD_CSUM)
    begin
      rd_decode = {21'h0_0000, count_q[RXEVC_SLOT_BAD_CSUM]};
    end
    else if (idx == `RXEVC_IDX_FILT_REJ)
    begin
      rd_decode = {21'h0_0000, count_q[RXEVC_SLOT_FILT_REJ]};
    end
    else if (idx == `RXEVC_IDX_OVERRUN)
    begin
      rd_decode = {21'h0_0000, count_q[RXEVC_SLOT_OVERRUN]};
    end
    else if (idx == `RXEVC_IDX_DLM_TMO)
    begin
      rd_decode = {21'h0_0000, count_q[RXEVC_SLOT_DLM_TMO]};
    end
  endfunction

  function automatic logic wr_mapped(input rxevc_addr_type a);
    logic [`RXEVC_ADDR_W-3:0] idx;
    idx = a[`RXEVC_ADDR_W-1:2];
    wr_mapped = (idx == `RXEVC_IDX_CONTROL) || (idx == `RXEVC_IDX_BAD_CSUM) ||
                (idx == `RXEVC_IDX_FILT_REJ) || (idx == `RXEVC_IDX_OVERRUN) ||
                (idx == `RXEVC_IDX_DLM_TMO);
  endfunction

  // A process rather than a continuous assignment, so that a change of any count
  // re-evaluates the decoded word and not only a change of the read address.
  always_comb
  begin
    rd_word = rd_decode(S_AXI_ARADDR);
  end

  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

  // Address and data are taken in either order; each ready stays low from its
  // handshake until the response is accepted, so one write is in flight at most.
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      awready_q <= 1'b1;
      aw_full_q <= 1'b0;
      waddr_q   <= '0;
    end
    else if (S_AXI_AWVALID && awready_q)
    begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b1;
      waddr_q   <= S_AXI_AWADDR;
    end
    else if (wr_fire)
    begin
      aw_full_q <= 1'b0;
    end
    else if (bvalid_q && S_AXI_BREADY)
    begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      wready_q <= 1'b1;
      w_full_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end
    else if (S_AXI_WVALID && wready_q)
    begin
      wready_q <= 1'b0;
      w_full_q <= 1'b1;
      wdata_q  <= S_AXI_WDATA;
      wstrb_q  <= S_AXI_WSTRB;
    end
    else if (wr_fire)
    begin
      w_full_q <= 1'b0;
    end
    else if (bvalid_q && S_AXI_BREADY)
    begin
      wready_q <= 1'b1;
    end
  end

  // Only the control word is writable; counter words accept the write and drop it.
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      cnt_en_q <= `RXEVC_EN_RESET;
    end
    else if (wr_fire && waddr_q[`RXEVC_ADDR_W-1:2] == `RXEVC_IDX_CONTROL && wstrb_q[0])
    begin
      cnt_en_q <= wdata_q[`RXEVC_BIT_CNT_EN];
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RXEVC_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped(waddr_q) ? `RXEVC_RESP_OKAY : `RXEVC_RESP_SLVERR;
    end
    else if (bvalid_q && S_AXI_BREADY)
    begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= `RXEVC_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word[`RXEVC_DATA_W-1:0];
      rresp_q   <= rd_word[`RXEVC_DATA_W] ? `RXEVC_RESP_SLVERR : `RXEVC_RESP_OKAY;
    end
    else if (rvalid_q && S_AXI_RREADY)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY  = wready_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

endmodule

// ---- verification/rxevc_counters_asserts.sv ----
// Purpose: Bus timing and field checks for the receive error event counters.
// Assumes: One clock domain with an asynchronous, active high reset.
// Notes:   Sees only the ports of rxevc_counters.
`timescale 1ns/1ps
module rxevc_counters_chk
  import rxevc_pkg::*;
(
  input wire logic                      SYS_CLK_I,     // Clock
  input wire logic                      RST_I,         // Reset
  input wire logic                      S_AXI_AWVALID, // Write address valid
  input wire logic                      S_AXI_AWREADY, // Write address ready
  input wire logic                      S_AXI_WVALID,  // Write data valid
  input wire logic                      S_AXI_WREADY,  // Write data ready
  input wire rxevc_pkg::rxevc_resp_type S_AXI_BRESP,   // Write response
  input wire logic                      S_AXI_BVALID,  // Write response valid
  input wire logic                      S_AXI_BREADY,  // Write response ready
  input wire logic                      S_AXI_ARVALID, // Read address valid
  input wire logic                      S_AXI_ARREADY, // Read address ready
  input wire rxevc_pkg::rxevc_data_type S_AXI_RDATA,   // Read data
  input wire logic                      S_AXI_RVALID,  // Read data valid
  input wire logic                      S_AXI_RREADY   // Read data ready
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  rd_upper_zero_a: assert property (
    S_AXI_RVALID |-> S_AXI_RDATA[31:12] == 20'h0_0000) else $error("Reserved bits read set");
  rd_answer_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("Read answer late");
  rd_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("Read data not held");
  rd_release_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=>
    !S_AXI_RVALID && S_AXI_ARREADY) else $error("Read not released");
  rd_busy_a: assert property (
    S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("Read address taken while busy");
  wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
    S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID) else $error("Write answer late");
  wr_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("Write response not held");
  wr_busy_a: assert property (S_AXI_BVALID |->
    !S_AXI_AWREADY && !S_AXI_WREADY) else $error("Write taken while busy");
endmodule

bind rxevc_counters rxevc_counters_chk chk (.*);

// ---- verification/rxevc_counters_bench.sv ----
// Purpose: Self-checking bench for the receive error event counters.
// Assumes: Byte address is four times the register index.
// Notes:   Events are kept idle while the bus is in use, so the model needs no bus timing.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module rxevc_counters_bench;
  import rxevc_pkg::*;
  logic SYS_CLK_I = 1'b0, RST_I = 1'b1, RX_CHECKSUM_ERROR_FLAG_I = 1'b0;
  logic FILTER_REJECT_FLAG_I = 1'b0, RX_OVERRUN_FLAG_I = 1'b0, RX_FRAME_DISCARD_I = 1'b0;
  logic RX_DELIMITER_TIMEOUT_FLAG_I = 1'b0, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
  logic S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  rxevc_addr_type S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  rxevc_data_type S_AXI_WDATA = 32'h0000_0000, S_AXI_RDATA, d;
  rxevc_resp_type S_AXI_BRESP, S_AXI_RRESP, r;
  rxevc_addr_type cnt_addr [4] = '{8'h28, 8'h30, 8'h38, 8'h40};
  rxevc_count_type m [4] = '{default: 12'h000};
  int n_errors = 0, checks_done = 0;
  logic en_m = 1'b0;
  rxevc_counters uut (.*);
  initial forever #10 SYS_CLK_I = ~SYS_CLK_I;
  function automatic rxevc_count_type bump(rxevc_count_type c, logic hit);
    return c + 12'(hit);
  endfunction
  // Reference counts, sampled at the same edge as the design.
  always @(posedge SYS_CLK_I)
    if (en_m && !RST_I)
    begin
      m[0] <= bump(m[0], RX_CHECKSUM_ERROR_FLAG_I);
      m[1] <= bump(m[1], FILTER_REJECT_FLAG_I);
      m[2] <= bump(m[2], RX_OVERRUN_FLAG_I & RX_FRAME_DISCARD_I);
      m[3] <= bump(m[3], RX_DELIMITER_TIMEOUT_FLAG_I);
    end
  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // A local flag ends the wait, since a ready set by non-blocking assignment
  // still reads its old value in the time step that sets it.
  task automatic wr(input rxevc_addr_type a, input rxevc_data_type v);
    bit done;
    done = 1'b0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (int i = 0; i < 20 && !done; i++)
    begin
      @(posedge SYS_CLK_I);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) begin r = S_AXI_BRESP; S_AXI_BREADY <= 1'b0; done = 1'b1; end
    end
    if (!done) begin n_errors++; stop_test; end
    @(posedge SYS_CLK_I);
  endtask
  task automatic rd(input rxevc_addr_type a);
    bit done;
    done = 1'b0;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (int i = 0; i < 20 && !done; i++)
    begin
      @(posedge SYS_CLK_I);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID)
      begin
        d = S_AXI_RDATA; r = S_AXI_RRESP; S_AXI_RREADY <= 1'b0; done = 1'b1;
      end
    end
    if (!done) begin n_errors++; stop_test; end
    @(posedge SYS_CLK_I);
  endtask
  task automatic check_all;
    for (int k = 0; k < 4; k++)
    begin
      rd(cnt_addr[k]);
      `CHK(d, {20'h0_0000, m[k]})
      `CHK(r, 2'b00)
    end
  endtask
  // A burst holds every event high; the 4100-cycle burst with counting enabled drives all counts through the wrap.
  task automatic ev(input int n, input bit burst);
    repeat (n)
    begin
      @(posedge SYS_CLK_I);
      RX_CHECKSUM_ERROR_FLAG_I <= burst | 1'($urandom);
      FILTER_REJECT_FLAG_I <= burst | 1'($urandom);
      RX_OVERRUN_FLAG_I <= burst | 1'($urandom);
      RX_FRAME_DISCARD_I <= burst | 1'($urandom);
      RX_DELIMITER_TIMEOUT_FLAG_I <= burst | 1'($urandom);
    end
    @(posedge SYS_CLK_I);
    {RX_CHECKSUM_ERROR_FLAG_I, FILTER_REJECT_FLAG_I, RX_OVERRUN_FLAG_I} <= 3'h0;
    {RX_FRAME_DISCARD_I, RX_DELIMITER_TIMEOUT_FLAG_I} <= 2'h0;
    @(posedge SYS_CLK_I);
  endtask
  initial
  begin
    void'($urandom(32'h69b442f3));
    repeat (10) @(posedge SYS_CLK_I);
    RST_I <= 1'b0;
    @(posedge SYS_CLK_I);
    check_all;
    ev(40, 1'b0);
    check_all;
    wr(8'h00, 32'h0000_0001);
    en_m = 1'b1;
    ev(300, 1'b0);
    check_all;
    ev(4100, 1'b1);
    check_all;
    for (int k = 0; k < 4; k++)
    begin
      wr(cnt_addr[k], $urandom);
      `CHK(r, 2'b00)
    end
    check_all;
    rd(8'h44);
    `CHK({r, d}, {2'b10, 32'h0000_0000})
    wr(8'h44, $urandom);
    `CHK(r, 2'b10)
    wr(8'h00, 32'h0000_0000);
    en_m = 1'b0;
    ev(30, 1'b1);
    check_all;
    RST_I <= 1'b1;
    repeat (2) @(posedge SYS_CLK_I);
    RST_I <= 1'b0;
    m = '{default: 12'h000};
    @(posedge SYS_CLK_I);
    check_all;
    stop_test;
  end
endmodule
